// file: pkg/wgrf_params.svh
// Offsets, field positions, reset values and timing counts of the waveform core.
// Assumes a 40 MHz clock and a 7-bit register address.
// What this block does
// - Channel 0 alone produces a continuous code waveform for PWM comparison.
// - Shape 0b000 makes a triangle ramping between low and high level codes.
// - Triangle period is two step intervals times ceiling of span over increment.
// - Shape 0b001 gives rising sawtooth, 0b010 gives falling sawtooth over same range.
// - Sawtooth period is step interval times ceiling of span over increment, plus one.
// - Oscillator error is held as two's complement, 0.2 percent per bit.
// - Reset loads stored defaults; bus access is accepted only after boot delay.
// - Key 0b1010 in trigger reset field starts a software reset like power-on.
// - Map lock bit set blocks writes to all registers except the trigger register.
// - Software reset through the trigger register still works while locked.
// - Key 0b0101 in trigger unlock field clears the lock and allows writes.
// - A CRC-16-CCITT is kept with stored data and checked at start-up.
// - Separate alarms flag user store and factory store check failures.
// - Check alarms change only during boot, never in normal operation.
// - On any alarm, registers take factory values and stay readable and writable.
// - Software reset or power cycle clears alarms and reloads user stored bits.
// - Output amplifier and internal reference power down independently.
// - Default: outputs enabled, internal reference off; store may change output state.
// - Power-down field: 00 up, 01 10k, 10 100k, 11 high impedance.
`ifndef WGRF_PARAMS_SVH
`define WGRF_PARAMS_SVH

`define WGRF_CLK_MHZ        40
`define WGRF_BOOT_NS        5000
`define WGRF_BOOT_CYC       ((`WGRF_BOOT_NS * `WGRF_CLK_MHZ + 999) / 1000)
`define WGRF_STEP_BASE_NS   1000
`define WGRF_STEP_BASE_CYC  ((`WGRF_STEP_BASE_NS * `WGRF_CLK_MHZ + 999) / 1000)

`define WGRF_OFS_FUNC_CFG   7'h00
`define WGRF_OFS_CODE_STEP  7'h01
`define WGRF_OFS_FUNC_MIN   7'h02
`define WGRF_OFS_FUNC_MAX   7'h03
`define WGRF_OFS_FREQ_ERR   7'h04
`define WGRF_OFS_COMMON     7'h05
`define WGRF_OFS_TRIGGER    7'h06
`define WGRF_OFS_STATUS     7'h07
`define WGRF_OFS_WAVE_CODE  7'h08

`define WGRF_SHAPE_TRI      3'h0
`define WGRF_SHAPE_SAW      3'h1
`define WGRF_SHAPE_INV      3'h2
`define WGRF_KEY_RESET      4'hA
`define WGRF_KEY_UNLOCK     4'h5
`define WGRF_BIT_LOCK       0
`define WGRF_BIT_INTREF     1

`define WGRF_RST_FUNC_CFG   16'h0000
`define WGRF_RST_CODE_STEP  10'h001
`define WGRF_RST_FUNC_MIN   10'h000
`define WGRF_RST_FUNC_MAX   10'h3FF
`define WGRF_RST_FREQ_ERR   8'h00
`define WGRF_RST_COMMON     6'h00
`define WGRF_CRC_INIT       16'hFFFF
`define WGRF_CRC_POLY       16'h1021
`define WGRF_USER_BITS      52
`define WGRF_FACT_BITS      8

`endif

// file: pkg/wgrf_pkg.sv
// Types shared by the waveform core and its bench.
// Assumes the constants header is compiled alongside.
package wgrf_pkg;

   typedef enum logic {WGRF_BOOT, WGRF_RUN} wgrf_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } wgrf_bus_req_t;

   typedef struct packed {
      logic [15:0] funcCfg;
      logic [9:0]  codeStep;
      logic [9:0]  minCode;
      logic [9:0]  maxCode;
      logic [5:0]  common;
      logic [15:0] crc;
   } wgrf_user_img_t;

   typedef struct packed {
      logic [7:0]  freqErr;
      logic [15:0] crc;
   } wgrf_fact_img_t;

endpackage

// file: hdl/wgrf_core.sv
// Waveform generator, boot check, reset, lock and power-down control.
// Assumes stored images are steady inputs and the bus master obeys strobe timing.
`timescale 1ns/1ps
`default_nettype none
`include "wgrf_params.svh"

module wgrf_core
(
   input  wire logic                    clock,
   input  wire logic                    rst_b,
   input  wire wgrf_pkg::wgrf_bus_req_t busReq,
   input  wire wgrf_pkg::wgrf_user_img_t userImage,
   input  wire wgrf_pkg::wgrf_fact_img_t factoryImage,
   output logic [15:0]                  readData_r,
   output logic [9:0]                   waveCode_r,
   output logic                         bootBusy_r,
   output logic                         intRefEn_r,
   output logic [15:0]                  storeCrc_r,
   output logic [1:0]                   outPoweredUp_r,
   output logic [1:0]                   outPull10k_r,
   output logic [1:0]                   outPull100k_r,
   output logic [1:0]                   outHiZ_r
);

   localparam logic [7:0] BOOT_LAST = 8'(`WGRF_BOOT_CYC - 1);
   localparam logic [5:0] BASE_LAST = 6'(`WGRF_STEP_BASE_CYC - 1);

   function automatic logic [15:0] wgrf_crc16(input logic [63:0] data, input int nbits);
      logic [15:0] c;
      logic        fb;
      c = `WGRF_CRC_INIT;
      for (int i = 63; i >= 0; i--)
      begin
         if (i < nbits)
         begin
            fb = c[15] ^ data[i];
            c  = {c[14:0], 1'b0} ^ (fb ? `WGRF_CRC_POLY : 16'h0000);
         end
      end
      return c;
   endfunction

   wgrf_pkg::wgrf_state_t state_r;
   wgrf_pkg::wgrf_state_t stateNxt;
   logic [7:0]  bootCnt_r;
   logic [7:0]  bootCntNxt;
   logic [15:0] funcCfg_r;
   logic [15:0] funcCfgNxt;
   logic [9:0]  codeStep_r;
   logic [9:0]  codeStepNxt;
   logic [9:0]  minCode_r;
   logic [9:0]  minCodeNxt;
   logic [9:0]  maxCode_r;
   logic [9:0]  maxCodeNxt;
   logic [7:0]  freqErr_r;
   logic [7:0]  freqErrNxt;
   logic [5:0]  common_r;
   logic [5:0]  commonNxt;
   logic        userAlarm_r;
   logic        userAlarmNxt;
   logic        factAlarm_r;
   logic        factAlarmNxt;
   logic [5:0]  baseCnt_r;
   logic [5:0]  baseCntNxt;
   logic [7:0]  stepCnt_r;
   logic [7:0]  stepCntNxt;
   logic        dirUp_r;
   logic        dirUpNxt;
   logic [9:0]  waveCodeNxt;
   logic [15:0] readDataNxt;
   logic [15:0] storeCrcNxt;
   logic        stepTick;
   logic        swResetHit;
   logic        locked;
   logic [63:0] userNow;
   logic [63:0] userStored;

   assign locked     = common_r[`WGRF_BIT_LOCK];
   assign stepTick   = (baseCnt_r == BASE_LAST) && (stepCnt_r == funcCfg_r[15:8]);
   assign swResetHit = (state_r == wgrf_pkg::WGRF_RUN) && busReq.wr && (busReq.addr == `WGRF_OFS_TRIGGER)
                       && (busReq.wdata[3:0] == `WGRF_KEY_RESET);
   assign userNow    = {12'h000, funcCfg_r, codeStep_r, minCode_r, maxCode_r, common_r};
   assign userStored = {12'h000, userImage.funcCfg, userImage.codeStep, userImage.minCode,
                        userImage.maxCode, userImage.common};

   always_comb
   begin
      logic [10:0] upSum;
      logic [10:0] downFloor;
      logic        userOk;
      logic        factOk;
      upSum        = {1'b0, waveCode_r} + {1'b0, codeStep_r};
      downFloor    = {1'b0, minCode_r} + {1'b0, codeStep_r};
      userOk       = 1'b0;
      factOk       = 1'b0;
      stateNxt     = state_r;
      bootCntNxt   = bootCnt_r;
      funcCfgNxt   = funcCfg_r;
      codeStepNxt  = codeStep_r;
      minCodeNxt   = minCode_r;
      maxCodeNxt   = maxCode_r;
      freqErrNxt   = freqErr_r;
      commonNxt    = common_r;
      userAlarmNxt = userAlarm_r;
      factAlarmNxt = factAlarm_r;
      baseCntNxt   = baseCnt_r;
      stepCntNxt   = stepCnt_r;
      dirUpNxt     = dirUp_r;
      waveCodeNxt  = waveCode_r;
      readDataNxt  = 16'h0000;
      storeCrcNxt  = wgrf_crc16(userNow, `WGRF_USER_BITS);
      case (state_r)
         wgrf_pkg::WGRF_BOOT:
         begin
            if (bootCnt_r == BOOT_LAST)
            begin
               userOk       = wgrf_crc16(userStored, `WGRF_USER_BITS) == userImage.crc;
               factOk       = wgrf_crc16({56'h0, factoryImage.freqErr}, `WGRF_FACT_BITS) == factoryImage.crc;
               userAlarmNxt = !userOk;
               factAlarmNxt = !factOk;
               if (userOk && factOk)
               begin
                  funcCfgNxt  = userImage.funcCfg;
                  codeStepNxt = userImage.codeStep;
                  minCodeNxt  = userImage.minCode;
                  maxCodeNxt  = userImage.maxCode;
                  commonNxt   = userImage.common;
               end
               if (factOk)
               begin
                  freqErrNxt = factoryImage.freqErr;
               end
               waveCodeNxt = (userOk && factOk) ? userImage.minCode : `WGRF_RST_FUNC_MIN;
               dirUpNxt    = 1'b1;
               baseCntNxt  = 6'h00;
               stepCntNxt  = 8'h00;
               stateNxt    = wgrf_pkg::WGRF_RUN;
            end
            else
            begin
               bootCntNxt = bootCnt_r + 8'h01;
            end
         end
         wgrf_pkg::WGRF_RUN:
         begin
            // Step timing: base tick, then programmable count of base ticks
            if (baseCnt_r == BASE_LAST)
            begin
               baseCntNxt = 6'h00;
               stepCntNxt = stepTick ? 8'h00 : stepCnt_r + 8'h01;
            end
            else
            begin
               baseCntNxt = baseCnt_r + 6'h01;
            end
            if (waveCode_r < minCode_r || waveCode_r > maxCode_r)
            begin
               waveCodeNxt = minCode_r;
               dirUpNxt    = 1'b1;
            end
            else if (stepTick)
            begin
               case (funcCfg_r[2:0])
                  `WGRF_SHAPE_TRI:
                  begin
                     if (dirUp_r)
                     begin
                        if (upSum >= {1'b0, maxCode_r})
                        begin
                           waveCodeNxt = maxCode_r;
                           dirUpNxt    = 1'b0;
                        end
                        else
                        begin
                           waveCodeNxt = upSum[9:0];
                        end
                     end
                     else if ({1'b0, waveCode_r} <= downFloor)
                     begin
                        waveCodeNxt = minCode_r;
                        dirUpNxt    = 1'b1;
                     end
                     else
                     begin
                        waveCodeNxt = waveCode_r - codeStep_r;
                     end
                  end
                  `WGRF_SHAPE_SAW:
                  begin
                     if (waveCode_r >= maxCode_r)
                        waveCodeNxt = minCode_r;
                     else if (upSum >= {1'b0, maxCode_r})
                        waveCodeNxt = maxCode_r;
                     else
                        waveCodeNxt = upSum[9:0];
                  end
                  `WGRF_SHAPE_INV:
                  begin
                     if (waveCode_r <= minCode_r)
                        waveCodeNxt = maxCode_r;
                     else if ({1'b0, waveCode_r} <= downFloor)
                        waveCodeNxt = minCode_r;
                     else
                        waveCodeNxt = waveCode_r - codeStep_r;
                  end
                  default:
                  begin
                     waveCodeNxt = minCode_r;
                  end
               endcase
            end
            // Register reads
            if (busReq.rd)
            begin
               case (busReq.addr)
                  `WGRF_OFS_FUNC_CFG:  readDataNxt = funcCfg_r;
                  `WGRF_OFS_CODE_STEP: readDataNxt = {6'h00, codeStep_r};
                  `WGRF_OFS_FUNC_MIN:  readDataNxt = {6'h00, minCode_r};
                  `WGRF_OFS_FUNC_MAX:  readDataNxt = {6'h00, maxCode_r};
                  `WGRF_OFS_FREQ_ERR:  readDataNxt = {8'h00, freqErr_r};
                  `WGRF_OFS_COMMON:    readDataNxt = {10'h000, common_r};
                  `WGRF_OFS_STATUS:    readDataNxt = {14'h0000, factAlarm_r, userAlarm_r};
                  `WGRF_OFS_WAVE_CODE: readDataNxt = {6'h00, waveCode_r};
                  default:             readDataNxt = 16'h0000;
               endcase
            end
            // Register writes
            if (swResetHit)
            begin
               stateNxt     = wgrf_pkg::WGRF_BOOT;
               bootCntNxt   = 8'h00;
               userAlarmNxt = 1'b0;
               factAlarmNxt = 1'b0;
               funcCfgNxt   = `WGRF_RST_FUNC_CFG;
               codeStepNxt  = `WGRF_RST_CODE_STEP;
               minCodeNxt   = `WGRF_RST_FUNC_MIN;
               maxCodeNxt   = `WGRF_RST_FUNC_MAX;
               freqErrNxt   = `WGRF_RST_FREQ_ERR;
               commonNxt    = `WGRF_RST_COMMON;
               waveCodeNxt  = `WGRF_RST_FUNC_MIN;
            end
            else if (busReq.wr && busReq.addr == `WGRF_OFS_TRIGGER)
            begin
               if (busReq.wdata[7:4] == `WGRF_KEY_UNLOCK)
                  commonNxt[`WGRF_BIT_LOCK] = 1'b0;
            end
            else if (busReq.wr && !locked)
            begin
               case (busReq.addr)
                  `WGRF_OFS_FUNC_CFG:  funcCfgNxt  = busReq.wdata;
                  `WGRF_OFS_CODE_STEP: codeStepNxt = busReq.wdata[9:0];
                  `WGRF_OFS_FUNC_MIN:  minCodeNxt  = busReq.wdata[9:0];
                  `WGRF_OFS_FUNC_MAX:  maxCodeNxt  = busReq.wdata[9:0];
                  `WGRF_OFS_FREQ_ERR:  freqErrNxt  = busReq.wdata[7:0];
                  `WGRF_OFS_COMMON:    commonNxt   = busReq.wdata[5:0];
                  default:             commonNxt   = common_r;
               endcase
            end
         end
         default:
         begin
            stateNxt = wgrf_pkg::WGRF_BOOT;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r     <= wgrf_pkg::WGRF_BOOT;
         bootCnt_r   <= 8'h00;
         funcCfg_r   <= `WGRF_RST_FUNC_CFG;
         codeStep_r  <= `WGRF_RST_CODE_STEP;
         minCode_r   <= `WGRF_RST_FUNC_MIN;
         maxCode_r   <= `WGRF_RST_FUNC_MAX;
         freqErr_r   <= `WGRF_RST_FREQ_ERR;
         common_r    <= `WGRF_RST_COMMON;
         userAlarm_r <= 1'b0;
         factAlarm_r <= 1'b0;
         baseCnt_r   <= 6'h00;
         stepCnt_r   <= 8'h00;
         dirUp_r     <= 1'b1;
         waveCode_r  <= `WGRF_RST_FUNC_MIN;
         readData_r  <= 16'h0000;
         storeCrc_r  <= 16'h0000;
         bootBusy_r  <= 1'b1;
         intRefEn_r  <= 1'b0;
      end
      else
      begin
         state_r     <= stateNxt;
         bootCnt_r   <= bootCntNxt;
         funcCfg_r   <= funcCfgNxt;
         codeStep_r  <= codeStepNxt;
         minCode_r   <= minCodeNxt;
         maxCode_r   <= maxCodeNxt;
         freqErr_r   <= freqErrNxt;
         common_r    <= commonNxt;
         userAlarm_r <= userAlarmNxt;
         factAlarm_r <= factAlarmNxt;
         baseCnt_r   <= baseCntNxt;
         stepCnt_r   <= stepCntNxt;
         dirUp_r     <= dirUpNxt;
         waveCode_r  <= waveCodeNxt;
         readData_r  <= readDataNxt;
         storeCrc_r  <= storeCrcNxt;
         bootBusy_r  <= (stateNxt == wgrf_pkg::WGRF_BOOT);
         intRefEn_r  <= commonNxt[`WGRF_BIT_INTREF];
      end
   end

   // Per-channel output stage decode
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         logic [1:0] pdnNxt;
         logic [3:0] modeNxt;
         always_comb
         begin
            pdnNxt  = commonNxt[2 + 2 * ch +: 2];
            modeNxt = 4'h0;
            case (pdnNxt)
               2'h0:    modeNxt = 4'h1;
               2'h1:    modeNxt = 4'h2;
               2'h2:    modeNxt = 4'h4;
               default: modeNxt = 4'h8;
            endcase
         end
         always_ff @(posedge clock or negedge rst_b)
         begin
            if (!rst_b)
            begin
               outPoweredUp_r[ch] <= 1'b1;
               outPull10k_r[ch]   <= 1'b0;
               outPull100k_r[ch]  <= 1'b0;
               outHiZ_r[ch]       <= 1'b0;
            end
            else
            begin
               outPoweredUp_r[ch] <= modeNxt[0];
               outPull10k_r[ch]   <= modeNxt[1];
               outPull100k_r[ch]  <= modeNxt[2];
               outHiZ_r[ch]       <= modeNxt[3];
            end
         end
      end
   endgenerate

   // Checks
   localparam int BOOT_LEN = `WGRF_BOOT_CYC;
   logic [8:0] busyLen;
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         busyLen <= 9'h000;
      else
         busyLen <= bootBusy_r ? busyLen + 9'h001 : 9'h000;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence s_write(logic [6:0] a);
      !bootBusy_r && busReq.wr && busReq.addr == a;
   endsequence
   sequence s_boot_entry;
      bootBusy_r && !userAlarm_r && !factAlarm_r;
   endsequence

   chk_boot_length: assert property ($fell(bootBusy_r) |-> busyLen == 9'(BOOT_LEN))
      else $error("boot delay length wrong");
   chk_swreset_entry: assert property (s_write(`WGRF_OFS_TRIGGER) ##0 busReq.wdata[3:0] == `WGRF_KEY_RESET
      |=> s_boot_entry ##0 minCode_r == `WGRF_RST_FUNC_MIN)
      else $error("software reset did not start boot");
   chk_lock_blocks: assert property (s_write(`WGRF_OFS_FUNC_MIN) ##0 locked |=> $stable(minCode_r))
      else $error("write passed while locked");
   chk_unlock_key: assert property (s_write(`WGRF_OFS_TRIGGER) ##0 busReq.wdata[7:4] == `WGRF_KEY_UNLOCK
      ##0 busReq.wdata[3:0] != `WGRF_KEY_RESET |=> !locked)
      else $error("unlock key ignored");
   chk_alarm_boot_only: assert property (!bootBusy_r && !swResetHit |=> $stable({userAlarm_r, factAlarm_r}))
      else $error("alarm changed outside boot");
   chk_alarm_defaults: assert property ($fell(bootBusy_r) && (userAlarm_r || factAlarm_r)
      |-> maxCode_r == `WGRF_RST_FUNC_MAX && common_r == `WGRF_RST_COMMON)
      else $error("factory values not used on alarm");
   chk_wave_range: assert property (!bootBusy_r && stepTick && !busReq.wr
      && waveCode_r >= minCode_r && waveCode_r <= maxCode_r |=> waveCode_r >= minCode_r && waveCode_r <= maxCode_r)
      else $error("wave code left range");
   chk_tri_turn: assert property (!bootBusy_r && stepTick && !busReq.wr && funcCfg_r[2:0] == `WGRF_SHAPE_TRI
      && dirUp_r && waveCode_r >= minCode_r && upSum_ge_max() |=> waveCode_r == maxCode_r && !dirUp_r)
      else $error("triangle top turn wrong");
   chk_saw_wrap: assert property (!bootBusy_r && stepTick && !busReq.wr && funcCfg_r[2:0] == `WGRF_SHAPE_SAW
      && waveCode_r == maxCode_r && minCode_r <= maxCode_r |=> waveCode_r == $past(minCode_r))
      else $error("sawtooth wrap wrong");
   chk_pdn_decode: assert property (!bootBusy_r && common_r[3:2] == 2'h3 |-> outHiZ_r[0] && !outPoweredUp_r[0])
      else $error("power-down decode wrong");

   function automatic logic upSum_ge_max();
      return ({1'b0, waveCode_r} + {1'b0, codeStep_r}) >= {1'b0, maxCode_r} && waveCode_r <= maxCode_r;
   endfunction

endmodule
`default_nettype wire

// file: hdl/unused_placeholder_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: test/wgrf_core_tb.sv
// Self-checking bench for the waveform, boot check, lock and power-down core.
// Assumes the constants header and the shared package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wgrf_params.svh"

module wgrf_core_tb;
   logic                     clock;
   logic                     rst_b;
   wgrf_pkg::wgrf_bus_req_t  busReq;
   wgrf_pkg::wgrf_user_img_t userImage;
   wgrf_pkg::wgrf_fact_img_t factoryImage;
   logic [15:0]              readData_r;
   logic [9:0]               waveCode_r;
   logic                     bootBusy_r;
   logic                     intRefEn_r;
   logic [15:0]              storeCrc_r;
   logic [1:0]               outPoweredUp_r;
   logic [1:0]               outPull10k_r;
   logic [1:0]               outPull100k_r;
   logic [1:0]               outHiZ_r;
   int                       bad_count = 0;
   int                       checked = 0;

   wgrf_core uut (.clock(clock), .rst_b(rst_b), .busReq(busReq), .userImage(userImage),
      .factoryImage(factoryImage), .readData_r(readData_r), .waveCode_r(waveCode_r),
      .bootBusy_r(bootBusy_r), .intRefEn_r(intRefEn_r), .storeCrc_r(storeCrc_r),
      .outPoweredUp_r(outPoweredUp_r), .outPull10k_r(outPull10k_r),
      .outPull100k_r(outPull100k_r), .outHiZ_r(outHiZ_r));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Bit-serial check value, MSB first
   function automatic logic [15:0] crc16(input logic [51:0] d, input int n);
      logic [15:0] c;
      c = `WGRF_CRC_INIT;
      for (int i = n - 1; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `WGRF_CRC_POLY : 16'h0000);
      return c;
   endfunction

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clock);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      busReq.wr <= 1'b0;
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge clock);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clock);
      busReq.rd <= 1'b0;
      #1;
      chk("readData", e, readData_r);
      @(posedge clock);
      #1;
      chk("readDataIdle", 16'h0000, readData_r);
   endtask

   task automatic wait_boot();
      for (int i = 0; i < 400 && bootBusy_r !== 1'b0; i++)
         @(posedge clock);
      chk("bootDone", 16'h0000, {15'h0000, bootBusy_r});
   endtask

   task automatic soft_reset();
      wr(`WGRF_OFS_TRIGGER, 16'h000A);
      #1;
      chk("bootBusy", 16'h0001, {15'h0000, bootBusy_r});
      wait_boot();
   endtask

   task automatic t_boot();
      @(posedge clock);
      rst_b <= 1'b1;
      rd(`WGRF_OFS_CODE_STEP, 16'h0000);
      wait_boot();
      rd(`WGRF_OFS_CODE_STEP, 16'h0003);
      rd(`WGRF_OFS_FUNC_MAX, 16'h0013);
      rd(`WGRF_OFS_STATUS, 16'h0000);
      chk("storeCrc", crc16(userImage[67:16], 52), storeCrc_r);
      chk("powerUp", 16'h0003, {14'h0000, outPoweredUp_r});
      chk("intRef", 16'h0001, {15'h0000, intRefEn_r});
      rd(7'h7F, 16'h0000);
      $display("test boot done");
   endtask

   task automatic t_pdn();
      for (int p = 0; p < 4; p++)
      begin
         wr(`WGRF_OFS_COMMON, {10'h000, 2'(3 - p), 2'(p), 2'b00});
         repeat (2) @(posedge clock);
         #1;
         chk("intRefOff", 16'h0000, {15'h0000, intRefEn_r});
         chk("up", {14'h0, 2'(3 - p) == 2'd0, 2'(p) == 2'd0}, {14'h0, outPoweredUp_r});
         chk("pull10k", {14'h0, 2'(3 - p) == 2'd1, 2'(p) == 2'd1}, {14'h0, outPull10k_r});
         chk("pull100k", {14'h0, 2'(3 - p) == 2'd2, 2'(p) == 2'd2}, {14'h0, outPull100k_r});
         chk("hiZ", {14'h0, 2'(3 - p) == 2'd3, 2'(p) == 2'd3}, {14'h0, outHiZ_r});
      end
      $display("test power-down done");
   endtask

   task automatic t_wave(input logic [2:0] shape, input int per, input logic [9:0] hi);
      int t0;
      int n;
      int d;
      logic [9:0] prev;
      wr(`WGRF_OFS_FUNC_CFG, {13'h0000, shape});
      prev = waveCode_r;
      n = 0;
      t0 = 0;
      for (int t = 0; t < 2000 && n < 3; t++)
      begin
         @(posedge clock);
         #1;
         if (waveCode_r !== prev && n > 0)
         begin
            d = (waveCode_r > prev) ? int'(waveCode_r - prev) : int'(prev - waveCode_r);
            chk("inRange", 16'h0001, {15'h0, waveCode_r >= 10'h00A && waveCode_r <= hi});
            chk("stepSize", 16'h0001, {15'h0, d == 3 || d == 9});
         end
         if (waveCode_r === 10'h00A && prev !== 10'h00A)
         begin
            if (n > 0)
               chk("period", 16'(per), 16'(t - t0));
            t0 = t;
            n++;
         end
         prev = waveCode_r;
      end
      chk("periods", 16'h0003, 16'(n));
      $display("test wave shape %0d done", shape);
   endtask

   task automatic t_lock();
      wr(`WGRF_OFS_COMMON, 16'h0003);
      wr(`WGRF_OFS_FUNC_MIN, 16'h0010);
      rd(`WGRF_OFS_FUNC_MIN, 16'h000A);
      wr(`WGRF_OFS_TRIGGER, 16'h0050);
      wr(`WGRF_OFS_FUNC_MIN, 16'h0010);
      rd(`WGRF_OFS_FUNC_MIN, 16'h0010);
      rd(`WGRF_OFS_TRIGGER, 16'h0000);
      $display("test lock done");
   endtask

   task automatic t_fault();
      wr(`WGRF_OFS_COMMON, 16'h0001);
      userImage.crc <= ~userImage.crc;
      rd(`WGRF_OFS_STATUS, 16'h0000);
      soft_reset();
      rd(`WGRF_OFS_STATUS, 16'h0001);
      chk("intRefDefault", 16'h0000, {15'h0000, intRefEn_r});
      chk("powerUpDefault", 16'h0003, {14'h0000, outPoweredUp_r});
      rd(`WGRF_OFS_CODE_STEP, 16'h0001);
      wr(`WGRF_OFS_CODE_STEP, 16'h0005);
      rd(`WGRF_OFS_CODE_STEP, 16'h0005);
      userImage.crc <= ~userImage.crc;
      factoryImage.crc <= ~factoryImage.crc;
      soft_reset();
      rd(`WGRF_OFS_STATUS, 16'h0002);
      rd(`WGRF_OFS_FREQ_ERR, 16'h0000);
      factoryImage.crc <= ~factoryImage.crc;
      soft_reset();
      rd(`WGRF_OFS_STATUS, 16'h0000);
      rd(`WGRF_OFS_CODE_STEP, 16'h0003);
      rd(`WGRF_OFS_FREQ_ERR, 16'h00F6);
      wr(`WGRF_OFS_FUNC_MAX, 16'h0016);
      t_wave(3'h0, 320, 10'h016);
      $display("test fault done");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clock);
      bad_count++;
      finish_test();
   end

   initial
   begin
      rst_b = 1'b0;
      busReq = '0;
      userImage = '{funcCfg: 16'h0000, codeStep: 10'h003, minCode: 10'h00A, maxCode: 10'h013,
         common: 6'h02, crc: 16'h0000};
      userImage.crc = crc16(userImage[67:16], 52);
      factoryImage = '{freqErr: 8'hF6, crc: 16'h0000};
      factoryImage.crc = crc16({44'h0, 8'hF6}, 8);
      repeat (5) @(posedge clock);
      t_boot();
      t_pdn();
      t_wave(3'h0, 240, 10'h013);
      t_wave(3'h1, 160, 10'h013);
      t_wave(3'h2, 160, 10'h013);
      t_lock();
      t_fault();
      finish_test();
   end
endmodule
`default_nettype wire
